// [logic/pcl_loader.v]
// Purpose: receive side of a passive parallel configuration port
// Assumes: config clock, data, reload and mode pins are asynchronous to mclk
// Notes:   config clock is oversampled; its period must span many mclk cycles
`timescale 1ns/1ps
`include "pcl_regs.vh"

// Functional notes
// - ratio 1, 4 with decryption, 8 with decompression
// - x8 uses bits 7..0, x16 bits 15..0
// - mode pins choose width, standard, power-on delay
// - chain-enable released for user after configuration
// - reload request low restarts configuration
// - load-complete low until whole image received
module pcl_loader #(
	parameter IMAGE_WORDS   = `PCL_IMAGE_WORDS,
	parameter POR_SHORT_CYC = `PCL_POR_SHORT_CYC,
	parameter POR_LONG_CYC  = `PCL_POR_LONG_CYC,
	parameter FIFO_DEPTH    = 32,
	parameter FIFO_AW       = 5
) (
	// clock and reset
	input  wire        mclk,
	input  wire        rstn,
	// configuration pins from the host
	input  wire        configClock,
	input  wire [31:0] configData,
	input  wire        reloadRequestN,
	input  wire [3:0]  modeSelectPins,
	// image options from on-chip logic
	input  wire        decompressEn,
	input  wire        decryptEn,
	input  wire        chainUnused,
	// status pins
	output reg         statusN,
	output reg         loadComplete,
	output reg         userMode,
	output reg         loadError,
	output reg         chainEnableOut,
	output reg         chainEnableOe,
	output reg  [1:0]  busWidth,
	output reg         ioStandard,
	// image word stream
	output wire [31:0] wordData,
	output wire        wordValid,
	input  wire        wordReady
);

	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam [5:0] ST_POR   = 6'h01;  // power-on delay
	localparam [5:0] ST_LOAD  = 6'h02;  // taking image words
	localparam [5:0] ST_DRAIN = 6'h04;  // trailing cycles after last word
	localparam [5:0] ST_INIT  = 6'h08;  // waiting for two falling edges
	localparam [5:0] ST_USER  = 6'h10;  // configured
	localparam [5:0] ST_ERROR = 6'h20;  // load failed

	// ------------------------------------------------------------
	// decoding functions
	// ------------------------------------------------------------
	function [3:0] ratioOf;
		input compress;
		input crypt;
		begin
			if (compress)
				ratioOf = `PCL_RATIO_PACKED;
			else if (crypt)
				ratioOf = `PCL_RATIO_CRYPT;
			else
				ratioOf = `PCL_RATIO_PLAIN;
		end
	endfunction

	function [31:0] laneMask;
		input [1:0] width;
		begin
			case (width)
				`PCL_WIDTH_X8:  laneMask = 32'h0000_00FF;
				`PCL_WIDTH_X16: laneMask = 32'h0000_FFFF;
				default:        laneMask = 32'hFFFF_FFFF;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	reg        clkMeta;       // first stage, read only by clkSync
	reg        clkSync;       // synchronised config clock
	reg        clkLast;       // previous value for edge finding
	reg [31:0] dataMeta;      // first stage of data bus
	reg [31:0] dataSync;      // synchronised data bus
	reg        reloadMeta;    // first stage of reload request
	reg        reloadSyncN;   // synchronised reload request
	reg [3:0]  modeMeta;      // first stage of mode pins
	reg [3:0]  modeSync;      // synchronised mode pins
	wire       clkRise;       // config clock rising edge
	wire       clkFall;       // config clock falling edge

	// two flops on every pin
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			clkMeta     <= 1'b0;
			clkSync     <= 1'b0;
			clkLast     <= 1'b0;
			dataMeta    <= 32'h0000_0000;
			dataSync    <= 32'h0000_0000;
			reloadMeta  <= 1'b1;
			reloadSyncN <= 1'b1;
			modeMeta    <= 4'h0;
			modeSync    <= 4'h0;
		end
		else
		begin
			clkMeta     <= configClock;
			clkSync     <= clkMeta;
			clkLast     <= clkSync;
			dataMeta    <= configData;
			dataSync    <= dataMeta;
			reloadMeta  <= reloadRequestN;
			reloadSyncN <= reloadMeta;
			modeMeta    <= modeSelectPins;
			modeSync    <= modeMeta;
		end
	end

	assign clkRise = clkSync && !clkLast;
	assign clkFall = !clkSync && clkLast;

	// ------------------------------------------------------------
	// capture path into the buffer
	// ------------------------------------------------------------
	reg  [5:0]  state;       // one-hot state
	reg  [3:0]  ratio;       // latched clock-to-word ratio
	reg  [3:0]  phase;       // rising edges into current word
	reg  [15:0] wordCount;   // words captured so far
	reg  [15:0] porCount;    // power-on delay counter
	reg  [1:0]  fallCount;   // falling edges seen after completion
	reg  [31:0] capData;     // word handed to the buffer
	reg         capValid;    // capture strobe to the buffer
	wire        bufReady;    // buffer can take a word
	wire        takeWord;    // this edge captures a word
	wire        lastWord;    // this capture ends the image

	assign takeWord = (state == ST_LOAD) && clkRise && (phase == 4'h0);
	assign lastWord = (wordCount == IMAGE_WORDS - 1);

	pcl_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.mclk     (mclk),
		.rstn     (rstn),
		.inData   (capData),
		.inValid  (capValid),
		.inReady  (bufReady),
		.outData  (wordData),
		.outValid (wordValid),
		.outReady (wordReady)
	);

	// ------------------------------------------------------------
	// load sequencer
	// ------------------------------------------------------------
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			state          <= ST_POR;
			ratio          <= `PCL_RATIO_PLAIN;
			phase          <= 4'h0;
			wordCount      <= 16'h0000;
			porCount       <= 16'h0000;
			fallCount      <= 2'h0;
			capData        <= 32'h0000_0000;
			capValid       <= 1'b0;
			statusN        <= 1'b0;
			loadComplete   <= 1'b0;
			userMode       <= 1'b0;
			loadError      <= 1'b0;
			chainEnableOut <= 1'b1;
			chainEnableOe  <= 1'b1;
			busWidth       <= `PCL_WIDTH_X8;
			ioStandard     <= 1'b0;
		end
		else
		begin
			capValid <= 1'b0;
			if (!reloadSyncN)
			begin
				// reload request holds sequencer, counters and flags at the start; width, standard and ratio keep their values
				state          <= ST_POR;
				porCount       <= 16'h0000;
				wordCount      <= 16'h0000;
				phase          <= 4'h0;
				fallCount      <= 2'h0;
				statusN        <= 1'b0;
				loadComplete   <= 1'b0;
				userMode       <= 1'b0;
				loadError      <= 1'b0;
				chainEnableOut <= 1'b1;
				chainEnableOe  <= 1'b1;
			end
			else
			begin
				case (state)
					ST_POR:
					begin
						// mode pins steer width, standard, delay
						busWidth   <= modeSync[`PCL_MODE_SELECT_PINS_WIDTH_HI:`PCL_MODE_SELECT_PINS_WIDTH_LO];
						ioStandard <= modeSync[`PCL_MODE_SELECT_PINS_STD_BIT];
						ratio      <= ratioOf(decompressEn, decryptEn);
						porCount   <= porCount + 16'h0001;
						if ((modeSync[`PCL_MODE_SELECT_PINS_POR_BIT] && porCount == POR_LONG_CYC - 1) ||
							(!modeSync[`PCL_MODE_SELECT_PINS_POR_BIT] && porCount == POR_SHORT_CYC - 1))
						begin
							statusN <= 1'b1;
							state   <= ST_LOAD;
						end
					end
					ST_LOAD:
					begin
						if (clkRise)
						begin
							// word position inside the ratio window
							phase <= (phase == ratio - 4'h1) ? 4'h0 : phase + 4'h1;
						end
						if (takeWord)
						begin
							if (!bufReady)
							begin
								// no room: image lost, flag it
								state     <= ST_ERROR;
								statusN   <= 1'b0;
								loadError <= 1'b1;
							end
							else
							begin
								capData   <= dataSync & laneMask(busWidth);
								capValid  <= 1'b1;
								wordCount <= wordCount + 16'h0001;
								if (lastWord && ratio == `PCL_RATIO_PLAIN)
								begin
									loadComplete <= 1'b1;
									state        <= ST_INIT;
								end
								else if (lastWord)
									state <= ST_DRAIN;
							end
						end
					end
					ST_DRAIN:
					begin
						// spend ratio minus one edges finishing the last word
						if (clkRise)
						begin
							phase <= phase + 4'h1;
							if (phase == ratio - 4'h1)
							begin
								loadComplete <= 1'b1;
								state        <= ST_INIT;
							end
						end
					end
					ST_INIT:
					begin
						// two falling edges carry the device into user mode
						if (clkFall)
						begin
							fallCount <= fallCount + 2'h1;
							if (fallCount == `PCL_INIT_FALLS - 2'h1)
							begin
								userMode       <= 1'b1;
								state          <= ST_USER;
								chainEnableOut <= 1'b0;
								chainEnableOe  <= !chainUnused;
							end
						end
					end
					ST_USER:
						state <= ST_USER;
					ST_ERROR:
						state <= ST_ERROR;
					default:
						state <= ST_POR;
				endcase
			end
		end
	end

endmodule

// [pkg/pcl_regs.vh]
// Purpose: constants for the passive parallel configuration loader
// Assumes: included by pcl_loader.v only
// Notes:   definitions only, no logic
`ifndef PCL_REGS_VH
`define PCL_REGS_VH

// ------------------------------------------------------------
// mode select field positions and width codes
// ------------------------------------------------------------
`define PCL_MODE_SELECT_PINS_WIDTH_LO   0
`define PCL_MODE_SELECT_PINS_WIDTH_HI   1
`define PCL_MODE_SELECT_PINS_STD_BIT    2
`define PCL_MODE_SELECT_PINS_POR_BIT    3
`define PCL_WIDTH_X8        2'h0
`define PCL_WIDTH_X16       2'h1
`define PCL_WIDTH_X32       2'h2

// ------------------------------------------------------------
// clock-to-word ratios
// ------------------------------------------------------------
`define PCL_RATIO_PLAIN     4'h1
`define PCL_RATIO_CRYPT     4'h4
`define PCL_RATIO_PACKED    4'h8

// ------------------------------------------------------------
// edge count, timing counts and image size
// ------------------------------------------------------------
`define PCL_INIT_FALLS      2'h2
`define PCL_POR_SHORT_CYC   100
`define PCL_POR_LONG_CYC    1000
`define PCL_IMAGE_WORDS     16

`endif

// [logic/pcl_fifo.v]
// Purpose: word buffer between the capture logic and the image consumer
// Assumes: single clock, asynchronous active-low reset
// Notes:   read data always come out of a register
`timescale 1ns/1ps

module pcl_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// clock and reset
	input  wire             mclk,
	input  wire             rstn,
	// filling side
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	// draining side
	output reg  [WIDTH-1:0] outData,
	output reg              outValid,
	input  wire             outReady
);

	// ------------------------------------------------------------
	// storage and pointers
	// ------------------------------------------------------------
	reg [WIDTH-1:0] mem [0:DEPTH-1];  // word storage
	reg [AW:0]      wrPtr;            // write pointer with wrap bit
	reg [AW:0]      rdPtr;            // read pointer with wrap bit
	wire [AW:0]     used;             // words held in memory
	wire            empty;            // nothing in memory
	wire            doWrite;          // word accepted this cycle
	wire            doRead;           // word moved to output register

	assign used    = wrPtr - rdPtr;
	assign empty   = (used == {(AW+1){1'b0}});
	assign inReady = (used != DEPTH[AW:0]) || (DEPTH[AW] == 1'b0 && used[AW]);
	assign doWrite = inValid && inReady;
	assign doRead  = !empty && (!outValid || outReady);

	// memory write, no reset needed on data
	always @(posedge mclk)
	begin
		if (doWrite)
			mem[wrPtr[AW-1:0]] <= inData;
	end

	// pointers and registered output stage
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			wrPtr    <= {(AW+1){1'b0}};
			rdPtr    <= {(AW+1){1'b0}};
			outData  <= {WIDTH{1'b0}};
			outValid <= 1'b0;
		end
		else
		begin
			if (doWrite)
				wrPtr <= wrPtr + 1'b1;
			if (doRead)
			begin
				// refill output register
				outData  <= mem[rdPtr[AW-1:0]];
				outValid <= 1'b1;
				rdPtr    <= rdPtr + 1'b1;
			end
			else if (outReady)
				outValid <= 1'b0;  // word taken, none behind it
		end
	end

endmodule

// [verif/pcl_host_model.sv]
// Purpose: configuration host that drives the link clock and data
// Assumes: link clock period 125 ns, unrelated to mclk
// Notes:   clock stands low between frames; released data shows inverse
`timescale 1ns/1ps
module pcl_host_model (
	// link pins
	output logic        configClock,
	output logic [31:0] configData
);
	initial
	begin
		configClock = 1'b0;
		configData  = 32'h0000_0000;
	end

	// one link clock cycle, low half first
	task pulse;
		#62.5 configClock = 1'b1;
		#62.5 configClock = 1'b0;
	endtask

	// one word, set while clock is low, held for r cycles
	// no release here: the next word follows in the same time step
	task word(input logic [31:0] d, input int r);
		configData = d;
		repeat (r) pulse();
	endtask

	// extra falling edges after completion, bus released to the inverse
	task tail(input int n);
		configData = ~configData;
		repeat (n) pulse();
	endtask
endmodule

// [verif/pcl_loader_assertions.sv]
// Purpose: port checks for the loader
// Assumes: bound to pcl_loader in tb_top
// Notes:   single mclk domain
`timescale 1ns/1ps
module pcl_loader_assertions (
	// clock, reset, pins
	input logic        mclk,
	input logic        rstn,
	input logic        configClock,
	input logic        reloadRequestN,
	input logic [3:0]  modeSelectPins,
	input logic        chainUnused,
	// status and stream
	input logic        statusN,
	input logic        loadComplete,
	input logic        userMode,
	input logic        loadError,
	input logic        chainEnableOut,
	input logic        chainEnableOe,
	input logic [1:0]  busWidth,
	input logic        ioStandard,
	input logic [31:0] wordData,
	input logic        wordValid,
	input logic        wordReady
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_chain_early: assert property (!userMode |-> chainEnableOut && chainEnableOe)
		else $error("chain enable released early");
	a_chain_user: assert property (userMode && $past(userMode) |->
		!chainEnableOut && chainEnableOe == !chainUnused)
		else $error("chain enable wrong in user mode");
	a_user_done: assert property (userMode |-> loadComplete)
		else $error("user mode without completion");
	a_user_order: assert property ($rose(userMode) |-> $past(loadComplete, 2))
		else $error("user mode came with completion");
	a_done_drop: assert property ($fell(loadComplete) |-> !$past(reloadRequestN, 2)
		|| !$past(reloadRequestN, 3) || !$past(reloadRequestN, 4))
		else $error("completion dropped without reload");
	a_done_edge: assert property ($rose(loadComplete) |-> $past(configClock, 2)
		|| $past(configClock, 3) || $past(configClock, 4) || $past(configClock, 5))
		else $error("completion not after a rising edge");
	a_err_status: assert property (loadError |-> !statusN)
		else $error("error without status low");
	a_word_hold: assert property (wordValid && !wordReady |=> wordValid && $stable(wordData))
		else $error("word dropped while stalled");
	a_width_pins: assert property ($rose(statusN) |-> busWidth == modeSelectPins[1:0]
		&& ioStandard == modeSelectPins[2])
		else $error("mode pins not followed");
endmodule

// [verif/tb_top.sv]
// Purpose: self-checking bench for the loader
// Assumes: host model drives the link, bench drives the rest
// Notes:   short power-on counts, 40-word image
`timescale 1ns/1ps
module tb_top;
	localparam int WORDS = 40;
	// inputs
	logic        mclk, rstn, reloadRequestN, decompressEn, decryptEn, chainUnused;
	logic        wordReady, stall, configClock;
	logic [3:0]  modeSelectPins;
	logic [31:0] configData;
	// outputs
	logic        statusN, loadComplete, userMode, loadError, chainEnableOut, chainEnableOe;
	logic        ioStandard, wordValid;
	logic [1:0]  busWidth;
	logic [31:0] wordData;
	// bookkeeping
	int          errors, n_tests, cycles;
	logic [31:0] q[$];

	pcl_host_model host (.configClock(configClock), .configData(configData));
	pcl_loader #(.IMAGE_WORDS(WORDS), .POR_SHORT_CYC(4), .POR_LONG_CYC(8)) dut (
		.mclk(mclk), .rstn(rstn), .configClock(configClock), .configData(configData),
		.reloadRequestN(reloadRequestN), .modeSelectPins(modeSelectPins),
		.decompressEn(decompressEn), .decryptEn(decryptEn), .chainUnused(chainUnused),
		.statusN(statusN), .loadComplete(loadComplete), .userMode(userMode),
		.loadError(loadError), .chainEnableOut(chainEnableOut),
		.chainEnableOe(chainEnableOe), .busWidth(busWidth), .ioStandard(ioStandard),
		.wordData(wordData), .wordValid(wordValid), .wordReady(wordReady));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task results;
		$display("errors %0d, checks %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one image load after a reload request
	task load(input int dc, input int cr, input logic [3:0] ms, input int n);
		int r, i, k;
		logic [31:0] w, m;
		r = dc ? 8 : (cr ? 4 : 1);
		m = (ms[1:0] == 2'h0) ? 32'h0000_00ff : (ms[1:0] == 2'h1) ? 32'h0000_ffff : '1;
		@(negedge mclk);
		modeSelectPins = ms;
		decompressEn = dc[0];
		decryptEn = cr[0];
		reloadRequestN = 1'b0;
		repeat (3) @(negedge mclk);
		reloadRequestN = 1'b1;
		for (k = 0; k < 40 && statusN !== 1'b1; k++) @(negedge mclk);
		check(statusN, 1);
		check(busWidth, ms[1:0]);
		check(ioStandard, ms[2]);
		for (i = 0; i < n; i++)
		begin
			w = $urandom;
			q.push_back(w & m);
			if (i == n - 1) check(loadComplete, 0);
			host.word(w, r);
		end
		if (n < WORDS) return;
		repeat (10) @(negedge mclk);
		check(loadComplete, 1);
		check(userMode, 0);
		host.tail(2);
		repeat (10) @(negedge mclk);
		check(userMode, 1);
		check(chainEnableOut, 0);
		check(chainEnableOe, !chainUnused);
		for (k = 0; k < 300 && q.size() != 0; k++) @(negedge mclk);
		check(q.size(), 0);
	endtask

	// mclk at 100 MHz
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// hang guard
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			errors++;
			$display("Error at %0t: timeout", $time);
			results();
		end
	end

	// far side stalls at random
	always @(negedge mclk) wordReady <= stall ? 1'b0 : ($urandom % 4 != 0);

	// stream watcher, oldest note first
	always @(posedge mclk)
		if (rstn === 1'b1 && wordValid === 1'b1 && wordReady === 1'b1)
		begin
			if (q.size() == 0)
			begin
				errors++;
				$display("Error at %0t: unexpected word", $time);
			end
			else
				check(wordData, q.pop_front());
		end

	// main sequence
	initial
	begin
		void'($urandom(65));
		rstn = 1'b0;
		reloadRequestN = 1'b1;
		decompressEn = 1'b0;
		decryptEn = 1'b0;
		modeSelectPins = 4'h0;
		stall = 1'b0;
		chainUnused = $urandom % 2;
		repeat (5) @(negedge mclk);
		rstn = 1'b1;
		for (int i = 0; i < 4; i++)
			load(i / 2, i % 2, {2'($urandom % 4), (i == 3) ? 2'h3 : 2'(i)}, WORDS);
		// fill the buffer until it refuses
		stall = 1'b1;
		load(0, 0, 4'h2, 36);
		repeat (20) @(negedge mclk);
		check(loadError, 1);
		check(statusN, 0);
		stall = 1'b0;
		repeat (100) @(negedge mclk);
		// 33 taken: 32 buffered plus the output register, the rest refused
		check(q.size(), 3);
		q.delete();
		results();
	end
endmodule

bind pcl_loader pcl_loader_assertions chk (.mclk(mclk), .rstn(rstn),
	.configClock(configClock), .reloadRequestN(reloadRequestN),
	.modeSelectPins(modeSelectPins), .chainUnused(chainUnused), .statusN(statusN),
	.loadComplete(loadComplete), .userMode(userMode), .loadError(loadError),
	.chainEnableOut(chainEnableOut), .chainEnableOe(chainEnableOe), .busWidth(busWidth),
	.ioStandard(ioStandard), .wordData(wordData), .wordValid(wordValid),
	.wordReady(wordReady));
